// ===== sbad_top.sv
// Purpose: Synchronous baud generator and autobaud detection unit
// Assumes: AHB-Lite slave, single word transfers, rxd synchronous to clock
// Notes: Zero wait states; unmapped addresses read zero, writes ignored
// Function
// - Synchronous mode: generator clock runs at four times the bit rate
// - Synchronous rate is clock over 8 or 12 times reload plus one
// - Reload value is an unsigned 13-bit number, 0 to 8191
// - Autobaud finds both frame format and bit rate on receive line
// - Only nine candidate rates tied to prescaler output are chosen
// - No free measurement of unknown rates; only candidate set recognised
// - Prescaler or fractional divider output is the autobaud time base
// - On success format bits and reload value are written automatically
// - Autobaud is unavailable in synchronous mode
// - Pairs a-t or A-T in five frame types; mixed case rejected
// - Candidate rate is prescaler output over 48 up to 9216
// - Slots zero to eight load reload values 2 to 575
// - Fixed divide-by-2 or divide-by-3 may also clock time base
// - Format 011, 111 or 001 written; odd parity sets odd bit
// - Begin and found interrupt lines each stay two clocks
`timescale 1ns/1ps
module sbad_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic rxd_i,
  output logic brt_tick_o,
  output logic shift_tick_o,
  output logic autobaud_begin_irq_o,
  output logic autobaud_found_irq_o
);
  logic rst_s1_q;
  logic rst_n;
  logic [sbad_pkg::CTRL_W-1:0] ctrl_q;
  logic [sbad_pkg::RELOAD_W-1:0] reload_q;
  logic [sbad_pkg::RELOAD_W-1:0] timer_val;
  logic [sbad_pkg::FRAC_W-1:0] frac_q;
  logic [sbad_pkg::FRAC_W:0] frac_sum;
  logic [sbad_pkg::FRAC_W-1:0] acc_q;
  logic [1:0] pre_q;
  logic [1:0] quarter_q;
  logic div_tick;
  logic underflow;
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  logic bus_wr_ctrl;
  logic bus_wr_reload;
  sbad_pkg::sbad_state_type state_q;
  logic [sbad_pkg::CNT_W-1:0] len_q;
  logic [sbad_pkg::CNT_W-1:0] cnt_q;
  logic [sbad_pkg::CNT_W-1:0] df_q;
  logic [sbad_pkg::GAP_W-1:0] gap_q;
  logic [3:0] slot_q;
  logic [3:0] bitn_q;
  logic [8:0] sh_q;
  logic [8:0] b1_q;
  logic rxd_prev_q;
  logic [4:0] slot_hit;
  logic [4:0] fmt_res;
  logic sample;
  logic begin_evt;
  logic found_evt;
  logic reject_evt;
  logic [1:0] begin_cnt_q;
  logic [1:0] found_cnt_q;
  logic ab_live;

  // Start bit width in time base ticks to slot, within one eighth
  function automatic logic [4:0] find_slot(input logic [sbad_pkg::CNT_W-1:0] n);
    logic [sbad_pkg::CNT_W-1:0] df;
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < sbad_pkg::SLOTS; i++)
    begin
      df = sbad_pkg::DF_TAB[i];
      if (n >= df - (df >> sbad_pkg::TOL_SH) && n <= df + (df >> sbad_pkg::TOL_SH))
        res = {1'b1, 4'(i)};
    end
    return res;
  endfunction

  function automatic logic parity7(input logic [8:0] b);
    return ^b[6:0];
  endfunction

  // Result {ok, mode, odd} from two nine-bit samples, b0 in bit 0
  function automatic logic [4:0] classify(input logic [8:0] c1, input logic [8:0] c2);
    logic pair_ok;
    logic [4:0] res;
    pair_ok = (c1[6:0] == sbad_pkg::CH_LA && c2[6:0] == sbad_pkg::CH_LT)
      || (c1[6:0] == sbad_pkg::CH_UA && c2[6:0] == sbad_pkg::CH_UT);
    res = 5'h00;
    if (!pair_ok)
      res = 5'h00;
    else if (!c1[7] && !c2[7] && c1[8] && c2[8])
      res = {1'b1, sbad_pkg::MODE_8N, 1'b0};
    else if (c1[8] && c2[8] && c1[7] == parity7(c1) && c2[7] == parity7(c2))
      res = {1'b1, sbad_pkg::MODE_7P, 1'b0};
    else if (c1[8] && c2[8] && c1[7] != parity7(c1) && c2[7] != parity7(c2))
      res = {1'b1, sbad_pkg::MODE_7P, 1'b1};
    else if (!c1[7] && !c2[7] && c1[8] == parity7(c1) && c2[8] == parity7(c2))
      res = {1'b1, sbad_pkg::MODE_8P, 1'b0};
    else if (!c1[7] && !c2[7] && c1[8] != parity7(c1) && c2[8] != parity7(c2))
      res = {1'b1, sbad_pkg::MODE_8P, 1'b1};
    return res;
  endfunction

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Bus slave
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else if (hready_i)
    begin
      wr_q <= hsel_i && htrans_i[1] && hwrite_i;
      addr_q <= haddr_i[7:0];
      if (hsel_i && htrans_i[1] && !hwrite_i)
      begin
        case (haddr_i[7:0])
          sbad_pkg::ADDR_CTRL: rdata_q <= {21'h000000, ctrl_q};
          sbad_pkg::ADDR_RELOAD: rdata_q <= {19'h00000, timer_val};
          sbad_pkg::ADDR_FRAC: rdata_q <= {23'h000000, frac_q};
          sbad_pkg::ADDR_STAT: rdata_q <= {17'h00000, state_q, slot_q, 4'h0};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign bus_wr_ctrl = wr_q && addr_q == sbad_pkg::ADDR_CTRL;
  assign bus_wr_reload = wr_q && addr_q == sbad_pkg::ADDR_RELOAD;
  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // Detector overrides format bits on success
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= sbad_pkg::CTRL_RST;
    else
    begin
      if (bus_wr_ctrl)
        ctrl_q <= hwdata_i[sbad_pkg::CTRL_W-1:0];
      if (found_evt)
      begin
        ctrl_q[sbad_pkg::CTRL_MODE_MSB:sbad_pkg::CTRL_MODE_LSB] <= fmt_res[3:1];
        ctrl_q[sbad_pkg::CTRL_ODD] <= fmt_res[0];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      reload_q <= sbad_pkg::RELOAD_RST;
    else if (found_evt)
      reload_q <= sbad_pkg::RELOAD_TAB[slot_q];
    else if (bus_wr_reload)
      reload_q <= hwdata_i[sbad_pkg::RELOAD_W-1:0];
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      frac_q <= sbad_pkg::FRAC_RST;
    else if (wr_q && addr_q == sbad_pkg::ADDR_FRAC)
      frac_q <= hwdata_i[sbad_pkg::FRAC_W-1:0];
  end

  // Prescaler: fractional n/512 when FDS is set in async mode, else fixed 2 or 3
  assign frac_sum = {1'b0, acc_q} + {1'b0, frac_q};
  always_comb
  begin
    div_tick = 1'b0;
    if (!ctrl_q[sbad_pkg::CTRL_RUN])
      div_tick = 1'b0;
    else if (ctrl_q[sbad_pkg::CTRL_FDS] && !ctrl_q[sbad_pkg::CTRL_SYNC])
      div_tick = (frac_q == sbad_pkg::FRAC_RST) || frac_sum[sbad_pkg::FRAC_W];
    else if (ctrl_q[sbad_pkg::CTRL_FPS])
      div_tick = pre_q == sbad_pkg::PRE3_LAST;
    else
      div_tick = pre_q == sbad_pkg::PRE2_LAST;
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= sbad_pkg::FRAC_RST;
      pre_q <= 2'h0;
    end
    else if (!ctrl_q[sbad_pkg::CTRL_RUN])
    begin
      acc_q <= sbad_pkg::FRAC_RST;
      pre_q <= 2'h0;
    end
    else
    begin
      acc_q <= frac_sum[sbad_pkg::FRAC_W-1:0];
      pre_q <= div_tick ? 2'h0 : pre_q + 2'h1;
    end
  end

  sbad_baud_timer u_timer (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .tick_i(div_tick),
    .run_i(ctrl_q[sbad_pkg::CTRL_RUN]),
    .load_i(bus_wr_reload || found_evt),
    .reload_i(reload_q),
    .value_o(timer_val),
    .underflow_o(underflow)
  );

  // Four underflows make one synchronous bit period
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      quarter_q <= 2'h0;
    else if (!ctrl_q[sbad_pkg::CTRL_SYNC])
      quarter_q <= 2'h0;
    else if (underflow)
      quarter_q <= quarter_q + 2'h1;
  end

  assign brt_tick_o = underflow;
  assign shift_tick_o = underflow && ctrl_q[sbad_pkg::CTRL_SYNC]
    && quarter_q == sbad_pkg::QUARTER_LAST;

  // Autobaud detector
  assign ab_live = ctrl_q[sbad_pkg::CTRL_AB_EN] && ctrl_q[sbad_pkg::CTRL_RUN]
    && !ctrl_q[sbad_pkg::CTRL_SYNC];
  assign slot_hit = find_slot(len_q);
  assign fmt_res = classify(b1_q, sh_q);
  assign sample = div_tick && cnt_q == 15'h0000;
  assign begin_evt = state_q == sbad_pkg::ST_IDLE && ab_live && rxd_prev_q && !rxd_i;
  assign found_evt = state_q == sbad_pkg::ST_BYTE2 && ab_live && bitn_q > sbad_pkg::LAST_BIT
    && fmt_res[4];
  assign reject_evt = ab_live && ((state_q == sbad_pkg::ST_START
    && ((rxd_i && !slot_hit[4]) || len_q > sbad_pkg::START_MAX))
    || (state_q == sbad_pkg::ST_BYTE2 && bitn_q > sbad_pkg::LAST_BIT && !fmt_res[4])
    || (state_q == sbad_pkg::ST_GAP && gap_q > {df_q, 4'h0}));

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rxd_prev_q <= 1'b1;
    else
      rxd_prev_q <= rxd_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= sbad_pkg::ST_IDLE;
      len_q <= 15'h0000;
      cnt_q <= 15'h0000;
      df_q <= 15'h0000;
      gap_q <= 19'h00000;
      slot_q <= 4'h0;
      bitn_q <= 4'h0;
      sh_q <= 9'h000;
      b1_q <= 9'h000;
    end
    else if (!ab_live || reject_evt)
      state_q <= sbad_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        sbad_pkg::ST_IDLE:
          if (begin_evt)
          begin
            state_q <= sbad_pkg::ST_START;
            len_q <= 15'h0000;
          end
        sbad_pkg::ST_START:
          if (rxd_i)
          begin
            state_q <= sbad_pkg::ST_BYTE1;
            slot_q <= slot_hit[3:0];
            df_q <= sbad_pkg::DF_TAB[slot_hit[3:0]];
            cnt_q <= (sbad_pkg::DF_TAB[slot_hit[3:0]] >> 1) - 15'h0001;
            bitn_q <= 4'h0;
          end
          else if (div_tick)
            len_q <= len_q + 15'h0001;
        sbad_pkg::ST_BYTE1, sbad_pkg::ST_BYTE2:
          if (state_q == sbad_pkg::ST_BYTE1 && bitn_q > sbad_pkg::LAST_BIT)
          begin
            b1_q <= sh_q;
            state_q <= sbad_pkg::ST_STOP1;
          end
          else if (state_q == sbad_pkg::ST_BYTE2 && bitn_q > sbad_pkg::LAST_BIT)
            state_q <= sbad_pkg::ST_DONE;
          else if (sample)
          begin
            sh_q <= {rxd_i, sh_q[8:1]};
            bitn_q <= bitn_q + 4'h1;
            cnt_q <= df_q - 15'h0001;
          end
          else if (div_tick)
            cnt_q <= cnt_q - 15'h0001;
        sbad_pkg::ST_STOP1:
          if (rxd_i)
          begin
            state_q <= sbad_pkg::ST_GAP;
            gap_q <= 19'h00000;
          end
        sbad_pkg::ST_GAP:
          if (!rxd_i)
          begin
            state_q <= sbad_pkg::ST_BYTE2;
            cnt_q <= df_q + (df_q >> 1) - 15'h0001;
            bitn_q <= 4'h0;
          end
          else if (div_tick)
            gap_q <= gap_q + 19'h00001;
        sbad_pkg::ST_DONE:
          state_q <= sbad_pkg::ST_DONE;
        default:
          state_q <= sbad_pkg::ST_IDLE;
      endcase
    end
  end

  // Two-clock interrupt pulses
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      begin_cnt_q <= 2'h0;
      found_cnt_q <= 2'h0;
    end
    else
    begin
      if (begin_evt && ctrl_q[sbad_pkg::CTRL_BEGIN_IE])
        begin_cnt_q <= sbad_pkg::IRQ_CYC;
      else if (begin_cnt_q != 2'h0)
        begin_cnt_q <= begin_cnt_q - 2'h1;
      if (found_evt && ctrl_q[sbad_pkg::CTRL_FOUND_IE])
        found_cnt_q <= sbad_pkg::IRQ_CYC;
      else if (found_cnt_q != 2'h0)
        found_cnt_q <= found_cnt_q - 2'h1;
    end
  end

  assign autobaud_begin_irq_o = begin_cnt_q != 2'h0;
  assign autobaud_found_irq_o = found_cnt_q != 2'h0;

  a_begin_two_clk: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(autobaud_begin_irq_o) |=> autobaud_begin_irq_o ##1 !autobaud_begin_irq_o)
    else $error("begin interrupt not two clocks");
  a_found_two_clk: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(autobaud_found_irq_o) |-> autobaud_found_irq_o [*2] ##1 !autobaud_found_irq_o)
    else $error("found interrupt not two clocks");
  a_sync_blocks_ab: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    ctrl_q[sbad_pkg::CTRL_SYNC] |=> state_q == sbad_pkg::ST_IDLE && !autobaud_found_irq_o)
    else $error("autobaud active in synchronous mode");
  a_reload_loaded: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    found_evt |=> reload_q == sbad_pkg::RELOAD_TAB[$past(slot_q)])
    else $error("reload not loaded from slot");
  a_format_loaded: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    found_evt |=> ctrl_q[sbad_pkg::CTRL_MODE_MSB:sbad_pkg::CTRL_MODE_LSB] == $past(fmt_res[3:1])
      && (ctrl_q[7:5] == sbad_pkg::MODE_7P || ctrl_q[7:5] == sbad_pkg::MODE_8P
      || ctrl_q[7:5] == sbad_pkg::MODE_8N))
    else $error("frame format not written");
  a_reject_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    reject_evt && !bus_wr_reload |=> state_q == sbad_pkg::ST_IDLE && $stable(reload_q))
    else $error("rejected frame changed state");
  a_shift_quarter: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    shift_tick_o |-> brt_tick_o && ctrl_q[sbad_pkg::CTRL_SYNC] ##1 quarter_q == 2'h0)
    else $error("shift tick off the fourth underflow");
  a_div_by_two: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    div_tick && ctrl_q[sbad_pkg::CTRL_SYNC] && !ctrl_q[sbad_pkg::CTRL_FPS] && $stable(ctrl_q)
      && !bus_wr_ctrl |=> !div_tick ##1 div_tick || !$stable(ctrl_q))
    else $error("divide by two prescaler wrong");
  a_div_by_three: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    div_tick && ctrl_q[sbad_pkg::CTRL_SYNC] && ctrl_q[sbad_pkg::CTRL_FPS] && !bus_wr_ctrl
      && !wr_q |=> !div_tick [*2])
    else $error("divide by three prescaler wrong");

  c_found: cover property (@(posedge core_clk_i) disable iff (!rst_n) found_evt);
  c_reject: cover property (@(posedge core_clk_i) disable iff (!rst_n) reject_evt);
  c_shift: cover property (@(posedge core_clk_i) disable iff (!rst_n) shift_tick_o);
endmodule

// ===== sbad_pkg.sv
// Purpose: Shared constants for the baud generator and autobaud detector
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: Register byte offsets, control bit positions, rate tables, states
package sbad_pkg;
  localparam int RELOAD_W = 13;
  localparam int FRAC_W = 9;
  localparam int CNT_W = 15;
  localparam int GAP_W = 19;
  localparam int CTRL_W = 11;
  localparam int SLOTS = 9;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RELOAD = 8'h04;
  localparam logic [7:0] ADDR_FRAC = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;

  // Control register bit positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SYNC = 1;
  localparam int CTRL_FPS = 2;
  localparam int CTRL_FDS = 3;
  localparam int CTRL_AB_EN = 4;
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL_MODE_MSB = 7;
  localparam int CTRL_ODD = 8;
  localparam int CTRL_BEGIN_IE = 9;
  localparam int CTRL_FOUND_IE = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [RELOAD_W-1:0] RELOAD_RST = 13'h0000;
  localparam logic [FRAC_W-1:0] FRAC_RST = 9'h000;

  // Prescaler and shift-clock divider terminal counts
  localparam logic [1:0] PRE2_LAST = 2'h1;
  localparam logic [1:0] PRE3_LAST = 2'h2;
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  localparam logic [2:0] MODE_7P = 3'h3;
  localparam logic [2:0] MODE_8P = 3'h7;
  localparam logic [2:0] MODE_8N = 3'h1;

  localparam logic [6:0] CH_LA = 7'h61;
  localparam logic [6:0] CH_LT = 7'h74;
  localparam logic [6:0] CH_UA = 7'h41;
  localparam logic [6:0] CH_UT = 7'h54;

  // Divide factors and reload values, slot 0 first
  localparam logic [CNT_W-1:0] DF_TAB [SLOTS] = '{15'h0030, 15'h0060, 15'h00C0,
    15'h0120, 15'h0240, 15'h0480, 15'h0900, 15'h1200, 15'h2400};
  localparam logic [RELOAD_W-1:0] RELOAD_TAB [SLOTS] = '{13'h0002, 13'h0005,
    13'h000B, 13'h0011, 13'h0023, 13'h0047, 13'h008F, 13'h011F, 13'h023F};

  localparam logic [CNT_W-1:0] START_MAX = 15'h2880;
  localparam int TOL_SH = 3;
  localparam int GAP_SH = 4;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [1:0] IRQ_CYC = 2'h2;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_START = 7'h02,
    ST_BYTE1 = 7'h04,
    ST_STOP1 = 7'h08,
    ST_GAP = 7'h10,
    ST_BYTE2 = 7'h20,
    ST_DONE = 7'h40
  } sbad_state_type;
endpackage

// ===== sbad_baud_timer.sv
// Purpose: 13-bit reloading down counter of the baud generator
// Assumes: tick_i is a one-cycle prescaler pulse
// Notes: A load while stopped waits until run is set
`timescale 1ns/1ps
module sbad_baud_timer (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic load_i,
  input wire logic [sbad_pkg::RELOAD_W-1:0] reload_i,
  output logic [sbad_pkg::RELOAD_W-1:0] value_o,
  output logic underflow_o
);
  logic [sbad_pkg::RELOAD_W-1:0] value_q;
  logic pend_q;
  logic load_q;

  // Load one clock late so a same-cycle reload register write is seen
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      load_q <= 1'b0;
    else
      load_q <= load_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pend_q <= 1'b0;
    else if (load_q && !run_i)
      pend_q <= 1'b1;
    else if (run_i)
      pend_q <= 1'b0;
  end

  // Reload on write, on deferred write and on every underflow
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      value_q <= sbad_pkg::RELOAD_RST;
    else if (run_i && (load_q || pend_q))
      value_q <= reload_i;
    else if (run_i && tick_i)
      value_q <= (value_q == sbad_pkg::RELOAD_RST) ? reload_i : value_q - 13'h0001;
  end

  assign underflow_o = run_i && tick_i && (value_q == sbad_pkg::RELOAD_RST);
  assign value_o = value_q;
endmodule

// ===== sbad_serial_sender.sv
// Purpose: Remote asynchronous sender of two-byte attention frames
// Assumes: Tasks are entered right after a rising clock edge
// Notes: Line idles high; bit period given in clock cycles
`timescale 1ns/1ps
module sbad_serial_sender (
  input wire logic core_clk_i,
  output logic rxd_o
);
  initial rxd_o = 1'b1;

  task automatic put(input logic b, input int per);
    rxd_o <= b;
    repeat (per) @(posedge core_clk_i);
  endtask

  // Start, data LSB first, optional parity (1 even, 2 odd), one stop
  task automatic send_byte(input logic [7:0] ch, input int nb, input int par, input int per);
    logic p;
    p = (nb == 7) ? ^ch[6:0] : ^ch;
    put(1'b0, per);
    for (int i = 0; i < nb; i++)
      put(ch[i], per);
    if (par != 0)
      put(p ^ (par == 2), per);
    put(1'b1, per);
  endtask

  task automatic send(input logic [7:0] c0, c1, input int nb, par, per);
    send_byte(c0, nb, par, per);
    put(1'b1, per);
    send_byte(c1, nb, par, per);
    put(1'b1, 2 * per);
  endtask
endmodule

// ===== tb_sync_baud_and_autobaud_detect.sv
// Purpose: Self-checking bench for baud generator and autobaud unit
// Assumes: Zero wait state slave, fractional value 0 gives a tick per clock
// Notes: Random reloads from a fixed xorshift seed
`timescale 1ns/1ps
module tb_sync_baud_and_autobaud_detect;
  logic clk, rst_n, hsel, hwrite, hready, hresp, rxd, brt, shf, irq_b, irq_f;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int fail_count, n_checks, cyc, brt_last, brt_gap, shf_last, shf_gap;
  int wb, wf, beg_w, fnd_w, beg_n, fnd_n;
  localparam int PER[5] = '{48, 96, 192, 288, 576};

  sbad_top i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .rxd_i(rxd), .brt_tick_o(brt), .shift_tick_o(shf), .autobaud_begin_irq_o(irq_b),
    .autobaud_found_irq_o(irq_f));
  sbad_serial_sender i_tx (.core_clk_i(clk), .rxd_o(rxd));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulse spacing and interrupt widths
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (brt === 1'b1)
    begin
      brt_gap <= cyc - brt_last;
      brt_last <= cyc;
    end
    if (shf === 1'b1)
    begin
      shf_gap <= cyc - shf_last;
      shf_last <= cyc;
    end
    if (irq_b === 1'b1)
      wb <= wb + 1;
    else if (wb != 0)
    begin
      beg_w <= wb;
      beg_n <= beg_n + 1;
      wb <= 0;
    end
    if (irq_f === 1'b1)
      wf <= wf + 1;
    else if (wf != 0)
    begin
      fnd_w <= wf;
      fnd_n <= fnd_n + 1;
      wf <= 0;
    end
    if (cyc == 60000)
    begin
      fail_count = fail_count + 1;
      $display("Error %0t: timeout", $time);
      end_of_test;
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk_val(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, exp, input string what);
    n_checks++;
    if (got != exp)
    begin
      fail_count++;
      $display("Error %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic sync_rate(input logic fps, input int r);
    int b0, k;
    k = fps ? 3 : 2;
    bus(1'b1, 32'(sbad_pkg::ADDR_CTRL), 32'h0);
    bus(1'b1, 32'(sbad_pkg::ADDR_RELOAD), 32'(r));
    bus(1'b1, 32'(sbad_pkg::ADDR_CTRL), 32'h13 | (32'(fps) << 2));
    b0 = beg_n;
    i_tx.send(8'h61, 8'h74, 8, 0, 48);
    chk_cnt(beg_n - b0, 0, "begin irq in sync");
    bus(1'b0, 32'(sbad_pkg::ADDR_STAT), 32'h0);
    chk_val(rd & 32'h7F00, 32'h100, "state in sync");
    chk_cnt(brt_gap, k * (r + 1), "timer period");
    chk_cnt(shf_gap, 4 * k * (r + 1), "shift period");
    $display("sync test fps %0d reload %0d done", fps, r);
  endtask

  // Frame type t: 0 8N, 1 7 even, 2 7 odd, 3 8 even, 4 8 odd
  task automatic detect(input int t, input logic [7:0] c0, c1, input int per,
    input logic good, input logic [31:0] base, input int slot);
    int nb, par, b0, f0;
    logic [31:0] m;
    nb = (t == 1 || t == 2) ? 7 : 8;
    par = (t == 0) ? 0 : ((t % 2 == 1) ? 1 : 2);
    m = (t == 0) ? 32'h20 : ((nb == 7) ? 32'h60 : 32'hE0);
    m = m | ((par == 2) ? 32'h100 : 32'h0);
    bus(1'b1, 32'(sbad_pkg::ADDR_CTRL), 32'h0);
    bus(1'b1, 32'(sbad_pkg::ADDR_FRAC), 32'h0);
    bus(1'b1, 32'(sbad_pkg::ADDR_CTRL), base & 32'hF);
    bus(1'b1, 32'(sbad_pkg::ADDR_CTRL), base);
    b0 = beg_n;
    f0 = fnd_n;
    i_tx.send(c0, c1, nb, par, per);
    repeat (20) @(posedge clk);
    bus(1'b0, 32'(sbad_pkg::ADDR_CTRL), 32'h0);
    if (good)
    begin
      chk_cnt(beg_n - b0, 1, "begin irq count");
      chk_cnt(beg_w, 2, "begin irq width");
      chk_cnt(fnd_n - f0, 1, "found irq count");
      chk_cnt(fnd_w, 2, "found irq width");
      chk_val(rd, base | m, "format bits");
      bus(1'b0, 32'(sbad_pkg::ADDR_STAT), 32'h0);
      chk_val(rd, 32'h4000 | (32'(slot) << 4), "slot");
      repeat (100) @(posedge clk);
      chk_cnt(brt_gap, per / 16, "loaded reload");
    end
    else
    begin
      chk_cnt(fnd_n - f0, 0, "found irq count");
      chk_val(rd, base, "control kept");
      bus(1'b0, 32'(sbad_pkg::ADDR_STAT), 32'h0);
      chk_val(rd & 32'h7F00, 32'h100, "back to idle");
    end
    $display("detect test type %0d period %0d done", t, per);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    seed = 32'hB32AB76F;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, 32'h10, 32'h0);
    chk_val(rd, 32'h0, "unmapped read");
    chk_val(32'(hresp), 32'h0, "response");
    $display("bus test done");
    sync_rate(1'b0, 0);
    sync_rate(1'b1, int'(xs() & 32'hF));
    sync_rate(1'b0, int'(xs() & 32'hF));
    for (int t = 0; t < 5; t++)
      detect(t, t[0] ? 8'h41 : 8'h61, t[0] ? 8'h54 : 8'h74, PER[t], 1'b1, 32'h619, t);
    detect(0, 8'h41, 8'h54, 192, 1'b1, 32'h611, 1);
    detect(0, 8'h61, 8'h54, 48, 1'b0, 32'h619, 0);
    detect(0, 8'h61, 8'h74, 40, 1'b0, 32'h619, 0);
    bus(1'b1, 32'(sbad_pkg::ADDR_RELOAD), 32'h7);
    repeat (100) @(posedge clk);
    chk_cnt(brt_gap, 8, "retuned reload");
    $display("retune test done");
    end_of_test;
  end
endmodule
